// file: inc/oldg_pkg.sv
package oldg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and timing, each time in its own unit with a derived cycle count
   localparam int CLK_PERIOD_NS = 25;
   localparam int NCH = 4;
   localparam int TMR_W = 17;
   localparam int ON_SHORT_US = 64;
   localparam int ON_LONG_US = 2000;
   localparam int LED_WIN_US = 2000;
   localparam int TRIG_WIN_US = 2000;
   localparam int TAIL_US = 100;
   localparam int OFF_TMO_US = 1200;
   localparam int FAULT_NS = 3300;
   // least times round up to whole cycles
   localparam int ON_SHORT_CYC = (ON_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ON_LONG_CYC = (ON_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LED_WIN_CYC = (LED_WIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIG_WIN_CYC = (TRIG_WIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TAIL_CYC = (TAIL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_TMO_CYC = (OFF_TMO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_CYC = (FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // register word indices on the plain register port
   localparam logic [3:0] ADDR_QUICK = 4'h1;
   localparam logic [3:0] ADDR_CH_BASE = 4'h2;
   localparam logic [3:0] ADDR_DEVICE = 4'h7;
   localparam logic [3:0] ADDR_OL_CTRL = 4'hd;
   localparam logic [3:0] ADDR_LED_CTRL = 4'he;

   // field positions
   localparam int GLB_OPEN_BIT = 8;
   localparam int CH_OFF_BIT = 0;
   localparam int CH_ON_BIT = 1;
   localparam int CH_OC_BIT = 4;
   localparam int CH_OTW_BIT = 5;
   localparam int CH_OTS_BIT = 6;
   localparam int DEV_UV_BIT = 2;
   localparam int DEV_CPF_BIT = 3;
   localparam int FILT_LSB = 0;
   localparam int OFF_EN_LSB = 4;
   localparam int LED_EN_LSB = 0;
   localparam int TRIG_BIT = 4;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // per-channel check state
   typedef enum logic [2:0] {
      S_IDLE,
      S_ON,
      S_LED,
      S_TRIG,
      S_TAIL,
      S_OFF
   } oldg_ch_state_t;

   // analog comparator and fault inputs, all asynchronous to clk
   typedef struct packed {
      logic [3:0] out_high;   // output above half supply
      logic [3:0] cur_low;    // load current under on-state threshold
      logic [3:0] led_cmp;    // output above supply minus led margin
      logic [3:0] off_thr;    // off-check current threshold reached
      logic [3:0] oc;         // overcurrent flags
      logic [3:0] otw;        // overtemperature warning
      logic [3:0] overtemp_shutdown_flag;        // overtemperature shutdown
      logic uv;               // undervoltage
      logic pump_fail_flag;              // charge pump failure
      logic serial_select_n;  // serial chip select
   } oldg_pins_t;

endpackage

// file: design/oldg_timer.sv
module oldg_timer #(
   parameter int W = 17
) (
   input wire logic clk,            // system clock
   input wire logic rst_n,          // async reset, active low
   input wire logic clear,          // restart from zero
   output logic [W-1:0] count       // cycles since clear, saturating
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } oldg_tmr_state_t;

   oldg_tmr_state_t q;
   oldg_tmr_state_t next_q;

   ////////////////////////////////////////////////////////////////////////////////
   // saturate so a forgotten timer never wraps into a false expiry
   always_comb
   begin
      next_q = q;
      if (clear)
         next_q.cnt = '0;
      else if (q.cnt != {W{1'b1}})
         next_q.cnt = q.cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= next_q;
   end

   assign count = q.cnt;

endmodule

// file: design/oldg_core.sv
module oldg_core #(
   parameter int ON_LONG = oldg_pkg::ON_LONG_CYC,
   parameter int LED_WIN = oldg_pkg::LED_WIN_CYC,
   parameter int TRIG_WIN = oldg_pkg::TRIG_WIN_CYC,
   parameter int OFF_TMO = oldg_pkg::OFF_TMO_CYC
) (
   input wire logic clk,                   // 40 MHz system clock
   input wire logic rst_n,                 // async reset, active low
   input wire logic [3:0] addr,            // register word index
   input wire logic [15:0] wdata,          // write data
   input wire logic wr,                    // write strobe
   input wire logic rd,                    // read strobe
   output logic [15:0] rdata,              // read data, cycle after rd
   input wire logic [3:0] out_cmd,         // turn-on commands, same clock
   input wire oldg_pkg::oldg_pins_t pins,  // asynchronous comparator inputs
   output logic [3:0] power_outputs,       // output switch drive
   output logic [3:0] led_test_current,    // led test source enable
   output logic [3:0] off_check_thr_sel,   // fixed off-check threshold
   output logic [3:0] channel_summary_flag, // per-channel summary
   output logic global_open_flag           // any open load latched
);

   typedef struct packed {
      oldg_pkg::oldg_pins_t s1;
      oldg_pkg::oldg_pins_t s2;
      logic sel_d;
      oldg_pkg::oldg_ch_state_t [3:0] st;
      logic [3:0] on_check_filter_select;
      logic [3:0] led_check_enable;
      logic [3:0] off_check_enable;
      logic led_check_trigger;
      logic trig_run;
      logic [3:0] on_open_flag;
      logic [3:0] on_from_led;
      logic [3:0] off_open_flag;
      logic [7:0] fault_cnt;
      logic [3:0] drive;
      logic [3:0] led_cur;
      logic [3:0] thr_sel;
      logic [3:0] summary;
      logic glob;
      logic [15:0] rdata;
   } oldg_state_t;

   localparam logic [7:0] FAULT_LIM = 8'(oldg_pkg::FAULT_CYC);
   localparam logic [16:0] ON_SHORT_END = 17'(oldg_pkg::ON_SHORT_CYC - 1);
   localparam logic [16:0] ON_LONG_END = 17'(ON_LONG - 1);
   localparam logic [16:0] LED_END = 17'(LED_WIN - 1);
   localparam logic [16:0] TRIG_END = 17'(TRIG_WIN - 1);
   localparam logic [16:0] TAIL_END = 17'(oldg_pkg::TAIL_CYC - 1);
   localparam logic [16:0] OFF_END = 17'(OFF_TMO - 1);

   oldg_state_t q;
   oldg_state_t next_q;
   logic [16:0] tcnt [4];
   logic [3:0] tclr;
   logic sel_rise;
   logic fault;
   logic trip;
   logic launch;
   logic busy;
   logic [3:0] rd_ch;
   logic [3:0] set_on;
   logic [3:0] set_off;
   logic [3:0] clr_on;

   ////////////////////////////////////////////////////////////////////////////////
   // one timer per channel so concurrent checks never share a count
   genvar g;
   generate
      for (g = 0; g < oldg_pkg::NCH; g++)
      begin : gen_tmr
         oldg_timer #(
            .W(oldg_pkg::TMR_W)
         ) u_tmr (
            .clk(clk),
            .rst_n(rst_n),
            .clear(tclr[g]),
            .count(tcnt[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic for the whole block
   always_comb
   begin
      next_q = q;
      tclr = '0;
      set_on = '0;
      set_off = '0;
      clr_on = '0;
      rd_ch = '0;
      // two-stage synchroniser, only stage two is looked at
      next_q.s1 = pins;
      next_q.s2 = q.s1;
      next_q.sel_d = q.s2.serial_select_n;
      sel_rise = q.s2.serial_select_n & ~q.sel_d;
      // common fault deglitch; a tripped fault aborts running off checks only and blocks new ones
      fault = q.s2.uv | q.s2.pump_fail_flag | (|q.s2.overtemp_shutdown_flag);
      trip = (q.fault_cnt == FAULT_LIM);
      if (!fault)
         next_q.fault_cnt = '0;
      else if (!trip)
         next_q.fault_cnt = q.fault_cnt + 8'h01;
      busy = 1'b0;
      for (int c = 0; c < oldg_pkg::NCH; c++)
         busy = busy | (q.st[c] == oldg_pkg::S_TRIG) | (q.st[c] == oldg_pkg::S_TAIL);
      launch = q.led_check_trigger & ~q.trig_run;
      if (launch)
         next_q.trig_run = 1'b1;
      else if (q.trig_run && !busy)
      begin
         next_q.trig_run = 1'b0;
         next_q.led_check_trigger = 1'b0;
      end
      // register writes
      if (wr)
      begin
         case (addr)
            oldg_pkg::ADDR_OL_CTRL:
            begin
               next_q.on_check_filter_select = wdata[oldg_pkg::FILT_LSB +: 4];
               for (int c = 0; c < oldg_pkg::NCH; c++)
                  if (q.st[c] != oldg_pkg::S_OFF)
                     next_q.off_check_enable[c] = wdata[oldg_pkg::OFF_EN_LSB + c];
            end
            oldg_pkg::ADDR_LED_CTRL:
            begin
               next_q.led_check_enable = wdata[oldg_pkg::LED_EN_LSB +: 4];
               if (!q.trig_run)
                  next_q.led_check_trigger = wdata[oldg_pkg::TRIG_BIT];
            end
            default:
               next_q.led_check_trigger = next_q.led_check_trigger;
         endcase
      end
      // register reads, data shows the flags as they stood before clearing
      next_q.rdata = '0;
      if (rd)
      begin
         case (addr)
            oldg_pkg::ADDR_QUICK:
            begin
               next_q.rdata[3:0] = q.summary;
               next_q.rdata[oldg_pkg::GLB_OPEN_BIT] = q.glob;
            end
            oldg_pkg::ADDR_DEVICE:
            begin
               next_q.rdata[oldg_pkg::DEV_UV_BIT] = q.s2.uv;
               next_q.rdata[oldg_pkg::DEV_CPF_BIT] = q.s2.pump_fail_flag;
               next_q.rdata[oldg_pkg::GLB_OPEN_BIT] = q.glob;
            end
            oldg_pkg::ADDR_OL_CTRL:
            begin
               next_q.rdata[oldg_pkg::FILT_LSB +: 4] = q.on_check_filter_select;
               next_q.rdata[oldg_pkg::OFF_EN_LSB +: 4] = q.off_check_enable;
            end
            oldg_pkg::ADDR_LED_CTRL:
            begin
               next_q.rdata[oldg_pkg::LED_EN_LSB +: 4] = q.led_check_enable;
               next_q.rdata[oldg_pkg::TRIG_BIT] = q.led_check_trigger;
            end
            default:
            begin
               for (int c = 0; c < oldg_pkg::NCH; c++)
                  if (addr == 4'(oldg_pkg::ADDR_CH_BASE + 4'(c)))
                  begin
                     rd_ch[c] = 1'b1;
                     next_q.rdata[oldg_pkg::CH_OFF_BIT] = q.off_open_flag[c];
                     next_q.rdata[oldg_pkg::CH_ON_BIT] = q.on_open_flag[c];
                     next_q.rdata[oldg_pkg::CH_OC_BIT] = q.s2.oc[c];
                     next_q.rdata[oldg_pkg::CH_OTW_BIT] = q.s2.otw[c];
                     next_q.rdata[oldg_pkg::CH_OTS_BIT] = q.s2.overtemp_shutdown_flag[c];
                     next_q.rdata[oldg_pkg::GLB_OPEN_BIT] = q.glob;
                  end
            end
         endcase
      end
      // per-channel check sequencer
      for (int c = 0; c < oldg_pkg::NCH; c++)
      begin
         case (q.st[c])
            oldg_pkg::S_IDLE:
            begin
               if (q.off_check_enable[c] && sel_rise && !trip)
                  next_q.st[c] = oldg_pkg::S_OFF;
               else if (out_cmd[c])
                  next_q.st[c] = oldg_pkg::S_ON;
            end
            oldg_pkg::S_ON:
            begin
               // a low output restarts the filter in either method
               if (!q.s2.out_high[c])
                  tclr[c] = 1'b1;
               if (!out_cmd[c])
                  next_q.st[c] = q.led_check_enable[c] ? oldg_pkg::S_LED
                                                       : oldg_pkg::S_IDLE;
               else if (launch && q.led_check_enable[c])
                  next_q.st[c] = oldg_pkg::S_TRIG;
               else if (!q.led_check_enable[c])
               begin
                  // filter restarts on every low output or good current
                  if (!q.s2.out_high[c] || !q.s2.cur_low[c])
                     tclr[c] = 1'b1;
                  else if (tcnt[c] >= (q.on_check_filter_select[c] ? ON_LONG_END
                                                                   : ON_SHORT_END))
                     set_on[c] = 1'b1;
               end
            end
            oldg_pkg::S_LED:
            begin
               if (!q.s2.led_cmp[c])
                  next_q.st[c] = oldg_pkg::S_IDLE;
               else if (out_cmd[c])
               begin
                  set_on[c] = 1'b1;
                  next_q.st[c] = oldg_pkg::S_ON;
               end
               else if (tcnt[c] >= LED_END)
               begin
                  set_on[c] = 1'b1;
                  next_q.st[c] = oldg_pkg::S_IDLE;
               end
            end
            oldg_pkg::S_TRIG:
            begin
               if (!q.s2.led_cmp[c])
                  next_q.st[c] = oldg_pkg::S_TAIL;
               else if (tcnt[c] >= TRIG_END)
               begin
                  set_on[c] = 1'b1;
                  next_q.st[c] = oldg_pkg::S_TAIL;
               end
            end
            oldg_pkg::S_TAIL:
            begin
               if (tcnt[c] >= TAIL_END)
                  next_q.st[c] = oldg_pkg::S_ON;
            end
            oldg_pkg::S_OFF:
            begin
               if (trip)
               begin
                  next_q.st[c] = oldg_pkg::S_IDLE;
                  next_q.off_check_enable[c] = 1'b0;
               end
               else if (q.s2.off_thr[c])
               begin
                  next_q.st[c] = oldg_pkg::S_IDLE;
                  next_q.off_check_enable[c] = 1'b0;
               end
               else if (tcnt[c] >= OFF_END)
               begin
                  set_off[c] = 1'b1;
                  next_q.st[c] = oldg_pkg::S_IDLE;
                  next_q.off_check_enable[c] = 1'b0;
               end
            end
            default:
               next_q.st[c] = oldg_pkg::S_IDLE;
         endcase
         if (next_q.st[c] != q.st[c])
            tclr[c] = 1'b1;
         // current-method flag waits for the fault to go; led flag does not
         clr_on[c] = rd_ch[c] && (q.on_from_led[c]
                     || !(q.s2.out_high[c] && q.s2.cur_low[c]));
         next_q.on_open_flag[c] = (q.on_open_flag[c] & ~clr_on[c]) | set_on[c];
         if (set_on[c])
            next_q.on_from_led[c] = q.led_check_enable[c];
         next_q.off_open_flag[c] = (q.off_open_flag[c] & ~rd_ch[c]) | set_off[c];
         // the flags never touch the drive of a commanded-on output
         next_q.drive[c] = (next_q.st[c] == oldg_pkg::S_ON)
                           || (next_q.st[c] == oldg_pkg::S_TAIL)
                           || (next_q.st[c] == oldg_pkg::S_OFF);
         next_q.led_cur[c] = (next_q.st[c] == oldg_pkg::S_LED)
                             || (next_q.st[c] == oldg_pkg::S_TRIG)
                             || (next_q.st[c] == oldg_pkg::S_TAIL);
         // separate select line: host overcurrent settings stay as written
         next_q.thr_sel[c] = (next_q.st[c] == oldg_pkg::S_OFF);
         next_q.summary[c] = q.s2.oc[c] | q.s2.otw[c] | q.s2.overtemp_shutdown_flag[c]
                             | next_q.on_open_flag[c] | next_q.off_open_flag[c];
      end
      next_q.glob = (|next_q.on_open_flag) | (|next_q.off_open_flag);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.s1.serial_select_n <= 1'b1;
         q.s2.serial_select_n <= 1'b1;
         q.sel_d <= 1'b1;
         q.off_check_enable <= oldg_pkg::CTRL_RESET;
      end
      else
         q <= next_q;
   end

   assign rdata = q.rdata;
   assign power_outputs = q.drive;
   assign led_test_current = q.led_cur;
   assign off_check_thr_sel = q.thr_sel;
   assign channel_summary_flag = q.summary;
   assign global_open_flag = q.glob;

   ////////////////////////////////////////////////////////////////////////////////
   // checks per channel
   generate
      for (g = 0; g < oldg_pkg::NCH; g++)
      begin : gen_chk
         AST_ON_KEEPS: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_ON && out_cmd[g] && !launch |=> power_outputs[g])
            else $error("output dropped while commanded on");
         AST_FILT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_ON && !q.s2.out_high[g] |=> tcnt[g] == '0)
            else $error("deglitch count survived a low output");
         AST_ON_GLOBAL: assert property (@(posedge clk) disable iff (!rst_n)
            $rose(q.on_open_flag[g]) |-> global_open_flag && channel_summary_flag[g])
            else $error("on-state result missing from summary flags");
         AST_OFF_START: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_IDLE && q.off_check_enable[g] && sel_rise && !trip
            |=> q.st[g] == oldg_pkg::S_OFF ##1 off_check_thr_sel[g] && power_outputs[g])
            else $error("off check did not start on select rise");
         AST_OFF_TMO: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_OFF && tcnt[g] >= OFF_END && !trip && !q.s2.off_thr[g]
            |=> q.off_open_flag[g] && !q.off_check_enable[g] ##1 !power_outputs[g])
            else $error("off timeout did not flag and end");
         AST_OFF_PASS: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_OFF && q.s2.off_thr[g] && !trip
            |=> !q.off_check_enable[g] && q.off_open_flag[g] == $past(q.off_open_flag[g]))
            else $error("threshold pass left check running or flagged");
         AST_OFF_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
            q.off_open_flag[g] && !rd_ch[g] |=> q.off_open_flag[g])
            else $error("off flag dropped without status read");
         AST_LED_PASS: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_LED && !q.s2.led_cmp[g] |=> ##1 !led_test_current[g])
            else $error("test current left on after pass");
         AST_TAIL_END: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_TAIL && tcnt[g] >= TAIL_END
            |=> q.st[g] == oldg_pkg::S_ON ##1 !led_test_current[g])
            else $error("test current tail did not end");
         AST_OFF_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
            q.st[g] == oldg_pkg::S_OFF && wr && !trip && !q.s2.off_thr[g] && tcnt[g] < OFF_END
            |=> q.off_check_enable[g] && q.st[g] == oldg_pkg::S_OFF)
            else $error("write disturbed a running off check");
      end
   endgenerate

   AST_TRIG_CLR: assert property (@(posedge clk) disable iff (!rst_n)
      q.trig_run && !busy |=> !q.led_check_trigger ##1 !q.trig_run)
      else $error("trigger bit did not clear after detection");

   COV_OFF_FLAG: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(q.off_open_flag[0]));
   COV_LED_FLAG: cover property (@(posedge clk) disable iff (!rst_n)
      q.st[3] == oldg_pkg::S_LED ##1 $rose(q.on_open_flag[3]));
   COV_TRIG_DONE: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(q.trig_run));
   COV_ABORT: cover property (@(posedge clk) disable iff (!rst_n)
      q.st[1] == oldg_pkg::S_OFF && trip);

endmodule

// file: dv/oldg_host.sv
module oldg_host (
   input wire logic clk, // system clock
   input wire logic wr, // each register write is one serial frame
   output logic serial_select_n // chip select, idles high
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold = 0;
   // select is held low through the frame; its release may start off checks
   always @(posedge clk)
      hold <= wr ? 3 : (hold > 0 ? hold - 1 : 0);
   assign serial_select_n = (hold == 0);
endmodule

// file: dv/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LW = 200, TMO = 150;
   logic clk = 1'b0, rst_n, wr, rd, sel_n, glob;
   logic [3:0] addr, out_cmd, pwr, cur, thr, summ;
   logic [15:0] wdata, rdata;
   oldg_pkg::oldg_pins_t pv;
   int err_total = 0, comparisons = 0;
   time t0 = 0;
   oldg_host host_u (.clk(clk), .wr(wr), .serial_select_n(sel_n)); // owns the select line
   oldg_core #(.ON_LONG(LW), .LED_WIN(LW), .TRIG_WIN(LW), .OFF_TMO(TMO)) dut_u (.clk(clk),
      .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .out_cmd(out_cmd), .pins({pv[$bits(pv)-1:1], sel_n}), .power_outputs(pwr),
      .led_test_current(cur), .off_check_thr_sel(thr), .channel_summary_flag(summ),
      .global_open_flag(glob));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      err_total += int'(got !== exp);
      if (got !== exp)
         $display("BAD %s expected %h seen %h", what, exp, got);
   endtask
   // one register cycle; a read compares the word with d
   task automatic bus(logic w, logic [3:0] a, logic [15:0] d, string what);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      {wr, rd} <= {w, !w};
      @(posedge clk);
      {wr, rd} <= 2'b00;
      #1 if (!w) chk(what, d, rdata);
   endtask
   // bounded wait on drive (0), test current (1) or summary (2), at least lo cycles past t0
   task automatic wt(int k, int ch, logic v, int lo, int hi);
      logic [3:0] s;
      for (int i = 0; i < hi; i++)
      begin
         @(posedge clk);
         #1 s = (k == 0) ? pwr : (k == 1) ? cur : summ;
         if (s[ch] === v)
            break;
      end
      chk("level", {14'h0000, v, 1'b1}, {14'h0000, s[ch], $time - t0 >= lo * 25});
   endtask
   task automatic close_out;
      $display("compared %0d mismatched %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
      forever #12.5 clk = ~clk; // 25 ns period
   // the run needs about eight thousand cycles; a hang is cut far beyond that
   initial
   begin
      repeat (40000) @(posedge clk);
      err_total++;
      close_out();
   end
   // ch2 stays commanded on and ch3 is off only for its led test, so only ch0 and ch1 get off checks
   initial
   begin
      {rst_n, wr, rd, addr, wdata, pv} = '0;
      out_cmd = 4'hc;
      void'($urandom(52));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, 4'hd, 16'h0000, "ol_ctrl");
      bus(0, 4'(8 + $urandom % 5), 16'h0000, "unmapped");
      // ch0 and ch1 start on one select edge; ch1 then meets its threshold
      bus(1, 4'hd, 16'h0030, "");
      wt(0, 1, 1'b1, 0, 20);
      t0 = $time;
      chk("drive", 16'h003f, {8'h00, thr, pwr});
      repeat (5 + $urandom % 40) @(posedge clk);
      pv.off_thr[1] <= 1'b1;
      wt(0, 1, 1'b0, 0, 8);
      bus(1, 4'hd, 16'h0000, "");
      bus(0, 4'hd, 16'h0010, "locked");
      wt(0, 0, 1'b0, TMO - 1, TMO);
      chk("flags", 16'h0011, {11'h000, glob, summ});
      bus(0, 4'hd, 16'h0000, "ctrl");
      bus(0, 4'h3, 16'h0100, "ch1");
      bus(0, 4'h2, 16'h0101, "ch0");
      bus(0, 4'h2, 16'h0000, "ch0 again");
      // current method on ch2, long filter then short, restarted by a one-cycle dip
      for (int f = 1; f >= 0; f--)
      begin
         bus(1, 4'hd, 16'(f << 2), "");
         pv.cur_low[2] <= 1'b1;
         pv.out_high[2] <= 1'b1;
         repeat (100) @(posedge clk);
         pv.out_high[2] <= 1'b0;
         @(posedge clk);
         pv.out_high[2] <= 1'b1;
         t0 = $time;
         wt(2, 2, 1'b1, f ? LW : oldg_pkg::ON_SHORT_CYC, 2570);
         wt(0, 2, 1'b1, 0, 1);
         bus(0, 4'h4, 16'h0102, "held");
         pv.cur_low[2] <= 1'b0;
         repeat (4) @(posedge clk);
         bus(0, 4'h4, 16'h0102, "last");
         bus(0, 4'h4, 16'h0000, "cleared");
      end
      // led mode on ch3 with the comparator stuck high, as an open led leaves it
      bus(1, 4'he, 16'h0008, "");
      // an open led keeps the comparator high while on; let it pass the synchroniser first
      pv.led_cmp[3] <= 1'b1;
      repeat (3) @(posedge clk);
      out_cmd[3] <= 1'b0;
      t0 = $time;
      wt(1, 3, 1'b1, 0, 8);
      wt(2, 3, 1'b1, LW, LW + 8);
      wt(1, 3, 1'b0, 0, 8);
      bus(0, 4'h5, 16'h0102, "led");
      out_cmd[3] <= 1'b1;
      bus(1, 4'he, 16'h0018, "");
      wt(0, 3, 1'b0, 0, 8);
      t0 = $time;
      wt(0, 3, 1'b1, LW - 1, LW + 8);
      t0 = $time;
      wt(1, 3, 1'b0, oldg_pkg::TAIL_CYC - 1, oldg_pkg::TAIL_CYC + 8);
      bus(0, 4'he, 16'h0008, "trigger");
      // undervoltage during an off check on ch1 aborts it with no flag
      pv.off_thr[1] <= 1'b0;
      bus(1, 4'hd, 16'h0020, "");
      wt(0, 1, 1'b1, 0, 20);
      t0 = $time;
      pv.uv <= 1'b1;
      wt(0, 1, 1'b0, oldg_pkg::FAULT_CYC, oldg_pkg::FAULT_CYC + 8);
      pv.uv <= 1'b0;
      bus(0, 4'hd, 16'h0000, "abort ctrl");
      bus(0, 4'h3, 16'h0100, "abort ch1");
      bus(0, 4'h5, 16'h0102, "trig flag");
      close_out();
   end
endmodule
